// ==== vsc_defs.svh ====
// Constants for the VME configuration-space slave: codes, offsets, timing.
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// Address modifier codes answered by the slave.
`define VSC_AM_CSR 6'h2F
`define VSC_AM_SGL 6'h09
`define VSC_AM_BLT 6'h0B

// Configuration space regions (19-bit byte offsets).
`define VSC_CR_END 19'h0_0FFF
`define VSC_UCSR_LO 19'h7_FBE0
`define VSC_UCSR_HI 19'h7_FBFF
`define VSC_BAR 19'h7_FFFF
`define VSC_BSET 19'h7_FFFB
`define VSC_BCLR 19'h7_FFF7
`define VSC_ADER_LO 19'h7_FF63

// User register offsets inside the user window (low five bits).
`define VSC_U_MODID 5'h00
`define VSC_U_PULSE 5'h04
`define VSC_U_ADRCTL 5'h08
`define VSC_U_STAT 5'h0C
`define VSC_U_VMEID 5'h10

// Normal A32 window offsets (27-bit byte offsets).
`define VSC_N_MODID 27'h000_0000
`define VSC_N_PULSE 27'h000_0008
`define VSC_N_ADRCTL 27'h000_0010
`define VSC_N_STAT 27'h000_0014
`define VSC_N_VMEID 27'h000_0020
`define VSC_N_MEM 27'h000_0200

// Configuration ROM byte offsets and fixed values.
`define VSC_ROM_CKS 12'h003
`define VSC_ROM_LEN 12'h007
`define VSC_ROM_CRW 12'h013
`define VSC_ROM_CSRW 12'h017
`define VSC_ROM_SPC 12'h01B
`define VSC_ROM_TAG1 12'h01F
`define VSC_ROM_TAG2 12'h023
`define VSC_ROM_MAKER 12'h027
`define VSC_ROM_BOARD 12'h033
`define VSC_ROM_REV 12'h043
`define VSC_WIDTH_CODE 8'h84
`define VSC_SPACE_CODE 8'h02
`define VSC_TAG1_VAL 8'h43
`define VSC_TAG2_VAL 8'h53

// Field positions, lane masks and reset values.
`define VSC_ADRCTL_OVR 5
`define VSC_FLAG_RESET 7
`define VSC_PULSE_MASK 10'h27F
`define VSC_LANE_D32 32'hFFFF_FFFF
`define VSC_LANE_D16 32'h0000_FFFF
`define VSC_LANE_D08 32'h0000_00FF
`define VSC_ZERO32 32'h0000_0000

// Reset pulse width in ns and its cycle count at the clock rate.
`define VSC_PULSE_NS 200
`define VSC_CLK_MHZ 100
`define VSC_PULSE_CYC ((`VSC_PULSE_NS * `VSC_CLK_MHZ + 999) / 1000)

`endif

// ==== vsc_pkg.sv ====
// Types shared by the configuration-space slave modules.
package vsc_pkg;

    // Bus cycle handler states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACK,
        ST_SKIP,
        ST_BLKWAIT
    } vsc_state_t;

    // Decoded target of one bus beat.
    typedef enum logic [3:0] {
        TG_NONE,
        TG_ZERO,
        TG_ROM,
        TG_BAR,
        TG_BSET,
        TG_BCLR,
        TG_ADER,
        TG_MODID,
        TG_PULSE,
        TG_ADRCTL,
        TG_STAT,
        TG_VMEID,
        TG_MEM
    } vsc_tgt_t;

    // Bus pins sampled as one request.
    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am;
        logic wr;
        logic [31:0] lanes;
    } vsc_req_t;

endpackage

// ==== vsc_cfg_rom.sv ====
// Configuration ROM: one byte per fourth address, unlisted bytes read zero.
`timescale 1ns/10ps
`include "vsc_defs.svh"
module vsc_cfg_rom #(
    parameter logic [7:0] CHECKSUM = 8'h00,
    parameter logic [23:0] ROM_LENGTH = 24'h00_0080,
    parameter logic [23:0] MAKER_ID = 24'h00_0000, // Arbitrary value.
    parameter logic [31:0] BOARD_IDENTIFIER = 32'h0000_0001, // Arbitrary value.
    parameter logic [31:0] REVISION = 32'h0000_0001 // Arbitrary value.
) (
    input wire logic [11:0] romAddr,
    output logic [7:0] romByte
);

    // Byte position within a multi-byte field, most significant first.
    logic [11:0] slotAddr;
    assign slotAddr = {romAddr[11:2], 2'b11}; // R18

    // -----------------------------------------------------------------
    // Table lookup
    // -----------------------------------------------------------------
    // Fixed table; anything not listed returns zero.
    always_comb
    begin
        case (slotAddr) // R17
            `VSC_ROM_CKS: romByte = CHECKSUM; // R20
            `VSC_ROM_LEN: romByte = ROM_LENGTH[23:16]; // R20
            `VSC_ROM_LEN + 12'h004: romByte = ROM_LENGTH[15:8];
            `VSC_ROM_LEN + 12'h008: romByte = ROM_LENGTH[7:0];
            `VSC_ROM_CRW: romByte = `VSC_WIDTH_CODE; // R19
            `VSC_ROM_CSRW: romByte = `VSC_WIDTH_CODE; // R19
            `VSC_ROM_SPC: romByte = `VSC_SPACE_CODE;
            `VSC_ROM_TAG1: romByte = `VSC_TAG1_VAL;
            `VSC_ROM_TAG2: romByte = `VSC_TAG2_VAL;
            `VSC_ROM_MAKER: romByte = MAKER_ID[23:16]; // R20
            `VSC_ROM_MAKER + 12'h004: romByte = MAKER_ID[15:8];
            `VSC_ROM_MAKER + 12'h008: romByte = MAKER_ID[7:0];
            `VSC_ROM_BOARD: romByte = BOARD_IDENTIFIER[31:24]; // R20
            `VSC_ROM_BOARD + 12'h004: romByte = BOARD_IDENTIFIER[23:16];
            `VSC_ROM_BOARD + 12'h008: romByte = BOARD_IDENTIFIER[15:8];
            `VSC_ROM_BOARD + 12'h00C: romByte = BOARD_IDENTIFIER[7:0];
            `VSC_ROM_REV: romByte = REVISION[31:24]; // R20
            `VSC_ROM_REV + 12'h004: romByte = REVISION[23:16];
            `VSC_ROM_REV + 12'h008: romByte = REVISION[15:8];
            `VSC_ROM_REV + 12'h00C: romByte = REVISION[7:0];
            default: romByte = 8'h00; // R17
        endcase
    end

endmodule

// ==== vsc_slave.sv ====
// VME slave with configuration space, user registers and a mapped memory.
//
// What this block does
// R1: Every mapped register except the pulse register can be read back.
// R2: Status read-only; control returns last written value.
// R3: Pulse register always reads zero.
// R4: Control and status reads are coherent snapshots.
// R5: Software reads status before touching changing registers.
// R6: Any access inside the space gets acknowledged.
// R7: All registers reset to zero.
// R8: Memory is directly mapped into bus space.
// R9: Answer only modifiers 2F, 09 and 0B.
// R10: Block transfers reach only the mapped memory.
// R11: 512 kbyte configuration space via modifier 2F.
// R12: Configuration space split into ROM and CSR areas.
// R13: Configuration space accepts byte, half and word widths.
// R14: Reset pulses come from always-present logic.
// R15: Configuration space holds load, address and version registers.
// R16: User registers mirrored in normal space under their own offsets.
// R17: ROM read-only; unlisted ROM bytes read zero.
// R18: ROM bytes sit at every fourth address.
// R19: ROM reports width code 84 twice.
// R20: ROM holds checksum, length, maker, board, revision.
// R21: A32 window is 27 bits, top from geography unless the override bit is set.
// R22: Writes to read-only places acknowledged and dropped.
`timescale 1ns/10ps
`include "vsc_defs.svh"
module vsc_slave #(
    parameter logic [31:0] MODULE_ID = 32'h0000_0001, // Arbitrary value.
    parameter logic [31:0] FW_REV = 32'h0000_0001, // Arbitrary value.
    parameter int MEM_WORDS = 8,
    parameter int PULSE_CYC = `VSC_PULSE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:1] vmeAddr,
    input wire logic [5:0] vmeAm,
    input wire logic asN,
    input wire logic ds0N,
    input wire logic ds1N,
    input wire logic lwordN,
    input wire logic writeN,
    input wire logic [4:0] gaN,
    input wire logic [31:0] dataIn,
    output logic [31:0] dataOut,
    output logic dataOe,
    output logic dtackOut,
    output logic dtackOe,
    input wire logic [31:0] statusIn,
    output logic [31:0] addrCtl,
    output logic [9:0] ctlPulse,
    output logic [7:0] csrFlags
);

    // -----------------------------------------------------------------
    // Constants and parameter checks
    // -----------------------------------------------------------------
    localparam int MEM_AW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;
    localparam logic [26:0] MEM_BYTES = 27'(MEM_WORDS * 4);
    localparam logic [18:0] UCSR_LO = `VSC_UCSR_LO;
    localparam logic [18:0] BAR_OFF = `VSC_BAR;
    localparam logic [18:0] BSET_OFF = `VSC_BSET;
    localparam logic [18:0] BCLR_OFF = `VSC_BCLR;
    localparam logic [18:0] ADER_OFF = `VSC_ADER_LO;

    // Refuse a memory size or pulse length the logic cannot serve.
    generate
        if (MEM_WORDS < 2 || MEM_WORDS > 64 ||
            (MEM_WORDS & (MEM_WORDS - 1)) != 0)
        begin : g_bad_mem
            $error("MEM_WORDS must be a power of two from 2 to 64.");
        end
        if (PULSE_CYC < 1 || PULSE_CYC > 255)
        begin : g_bad_pulse
            $error("PULSE_CYC must lie between 1 and 255.");
        end
    endgenerate

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    vsc_pkg::vsc_state_t stateR; // Bus cycle handler state.
    vsc_pkg::vsc_state_t stateNxt; // Next handler state.
    logic [31:0] blkAddrR; // Next beat address of a block transfer.
    logic [31:0] dataOutR; // Read data held for the master.
    logic readR; // Current beat is a read.
    logic [7:0] barR; // Base address byte.
    logic [7:0] csrFlagsR; // Flags set and cleared by bit registers.
    logic [31:0] aderR; // Address/data compare word.
    logic [31:0] adrCtlR; // Addressing control word.
    logic [9:0] pulseR; // Active reset pulses.
    logic [7:0] pulseCntR; // Cycles left on the reset pulses.
    logic [31:0] memR [MEM_WORDS]; // Directly mapped memory.

    // -----------------------------------------------------------------
    // Request sampling and decode
    // -----------------------------------------------------------------
    vsc_pkg::vsc_req_t req; // Current beat as one bundle.
    vsc_pkg::vsc_tgt_t tgt; // Decoded target.
    logic [4:0] slot; // Slot number from the geography pins.
    logic [4:0] base5; // Top five bits of the A32 window.
    logic [18:0] cfgOff; // Offset inside configuration space.
    logic [26:0] nrmOff; // Offset inside the A32 window.
    logic [26:0] memOff; // Offset inside the memory block.
    logic [MEM_AW-1:0] memIdx; // Word index into the memory.
    logic take; // A beat is taken this cycle.
    logic wrStb; // The taken beat writes.
    logic [31:0] rdVal; // Value answered to a read.
    logic [7:0] romByte; // Byte from the configuration ROM.
    logic [7:0] aderByte; // Selected compare byte.
    logic [31:0] wrVal; // Write data with only the used lanes.

    // Build the request from the pins or the block address counter.
    always_comb
    begin
        req.addr = (stateR == vsc_pkg::ST_BLKWAIT) ?
            blkAddrR : {vmeAddr, 1'b0};
        req.am = vmeAm;
        req.wr = !writeN;
        if (!lwordN)
            req.lanes = `VSC_LANE_D32; // R13
        else if (!ds0N && !ds1N)
            req.lanes = `VSC_LANE_D16; // R13
        else
            req.lanes = `VSC_LANE_D08; // R13
    end

    // Window base: geography unless the override bit is set.
    assign slot = ~gaN;
    assign base5 = adrCtlR[`VSC_ADRCTL_OVR] ? adrCtlR[4:0] : slot; // R21
    assign cfgOff = req.addr[18:0]; // R11
    assign nrmOff = req.addr[26:0]; // R21
    assign memOff = nrmOff - `VSC_N_MEM;
    assign memIdx = memOff[MEM_AW+1:2];
    assign wrVal = dataIn & req.lanes;

    // Target decode; a hit inside the space is never left unanswered.
    always_comb
    begin
        tgt = vsc_pkg::TG_NONE;
        if (req.am == `VSC_AM_CSR && req.addr[23:19] == slot) // R9 R11
        begin
            tgt = vsc_pkg::TG_ZERO; // R6
            if (cfgOff <= `VSC_CR_END) // R12
                tgt = vsc_pkg::TG_ROM;
            else if (cfgOff >= `VSC_UCSR_LO && cfgOff <= `VSC_UCSR_HI)
            begin
                case (cfgOff[4:0] & 5'h1C) // R16
                    `VSC_U_MODID: tgt = vsc_pkg::TG_MODID;
                    `VSC_U_PULSE: tgt = vsc_pkg::TG_PULSE;
                    `VSC_U_ADRCTL: tgt = vsc_pkg::TG_ADRCTL; // R15
                    `VSC_U_STAT: tgt = vsc_pkg::TG_STAT;
                    `VSC_U_VMEID: tgt = vsc_pkg::TG_VMEID; // R15
                    default: tgt = vsc_pkg::TG_ZERO;
                endcase
            end
            else if (cfgOff[18:2] == BAR_OFF[18:2]) // R12
                tgt = vsc_pkg::TG_BAR;
            else if (cfgOff[18:2] == BSET_OFF[18:2])
                tgt = vsc_pkg::TG_BSET;
            else if (cfgOff[18:2] == BCLR_OFF[18:2])
                tgt = vsc_pkg::TG_BCLR;
            else if (cfgOff[18:4] == ADER_OFF[18:4])
                tgt = vsc_pkg::TG_ADER;
        end
        else if ((req.am == `VSC_AM_SGL || req.am == `VSC_AM_BLT) &&
            req.addr[31:27] == base5) // R9 R21
        begin
            tgt = vsc_pkg::TG_ZERO; // R6
            if (memOff < MEM_BYTES) // R8
                tgt = vsc_pkg::TG_MEM;
            else if (req.am == `VSC_AM_BLT)
                tgt = vsc_pkg::TG_ZERO; // R10
            else
            begin
                case (nrmOff) // R16
                    `VSC_N_MODID: tgt = vsc_pkg::TG_MODID;
                    `VSC_N_PULSE: tgt = vsc_pkg::TG_PULSE;
                    `VSC_N_ADRCTL: tgt = vsc_pkg::TG_ADRCTL;
                    `VSC_N_STAT: tgt = vsc_pkg::TG_STAT;
                    `VSC_N_VMEID: tgt = vsc_pkg::TG_VMEID;
                    default: tgt = vsc_pkg::TG_ZERO;
                endcase
            end
        end
    end

    // A beat starts on a data strobe while the address strobe is low.
    assign take = ce && !asN && (!ds0N || !ds1N) &&
        (stateR == vsc_pkg::ST_IDLE || stateR == vsc_pkg::ST_BLKWAIT);
    assign wrStb = take && req.wr && tgt != vsc_pkg::TG_NONE;

    // Configuration ROM lookup.
    vsc_cfg_rom u_rom (
        .romAddr(cfgOff[11:0]),
        .romByte(romByte)
    );

    // Compare word byte, first address holds the top byte.
    assign aderByte = aderR[{~cfgOff[3:2], 3'b000} +: 8];

    // -----------------------------------------------------------------
    // Read multiplexer
    // -----------------------------------------------------------------
    // Chooses the answer; pulse and unlisted places read zero.
    always_comb
    begin
        case (tgt) // R1
            vsc_pkg::TG_ROM: rdVal = {24'h00_0000, romByte}; // R17
            vsc_pkg::TG_BAR: rdVal = {24'h00_0000, barR};
            vsc_pkg::TG_BSET: rdVal = {24'h00_0000, csrFlagsR};
            vsc_pkg::TG_BCLR: rdVal = {24'h00_0000, csrFlagsR};
            vsc_pkg::TG_ADER: rdVal = {24'h00_0000, aderByte};
            vsc_pkg::TG_MODID: rdVal = MODULE_ID;
            vsc_pkg::TG_PULSE: rdVal = `VSC_ZERO32; // R3
            vsc_pkg::TG_ADRCTL: rdVal = adrCtlR; // R2
            vsc_pkg::TG_STAT: rdVal = statusIn; // R2
            vsc_pkg::TG_VMEID: rdVal = FW_REV;
            vsc_pkg::TG_MEM: rdVal = memR[memIdx]; // R8
            default: rdVal = `VSC_ZERO32;
        endcase
    end

    // -----------------------------------------------------------------
    // Bus cycle handler
    // -----------------------------------------------------------------
    // Next state: acknowledge hits, stay silent on misses until released.
    always_comb
    begin
        stateNxt = stateR;
        unique case (stateR)
            vsc_pkg::ST_IDLE, vsc_pkg::ST_BLKWAIT:
            begin
                if (ce && asN)
                    stateNxt = vsc_pkg::ST_IDLE;
                else if (take)
                    stateNxt = (tgt != vsc_pkg::TG_NONE) ?
                        vsc_pkg::ST_ACK : vsc_pkg::ST_SKIP; // R6 R9
            end
            vsc_pkg::ST_ACK:
            begin
                if (ce && asN)
                    stateNxt = vsc_pkg::ST_IDLE;
                else if (ce && ds0N && ds1N)
                    stateNxt = (vmeAm == `VSC_AM_BLT) ?
                        vsc_pkg::ST_BLKWAIT : vsc_pkg::ST_IDLE;
            end
            vsc_pkg::ST_SKIP:
            begin
                if (ce && asN)
                    stateNxt = vsc_pkg::ST_IDLE;
            end
        endcase
    end

    // Handler state register.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            stateR <= vsc_pkg::ST_IDLE;
        else if (ce)
            stateR <= stateNxt;
    end

    // Block transfer address advances one word per beat.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            blkAddrR <= `VSC_ZERO32;
        else if (take)
            blkAddrR <= req.addr + 32'h0000_0004; // R10
    end

    // Read data is caught once when the beat is taken, so it stays
    // steady while the master samples it.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            dataOutR <= `VSC_ZERO32;
            readR <= 1'b0;
        end
        else if (take)
        begin
            dataOutR <= rdVal & req.lanes; // R4 R13
            readR <= !req.wr;
        end
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    // Base address byte and compare word, both read/write.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            barR <= 8'h00; // R7
            aderR <= `VSC_ZERO32; // R7
        end
        else if (wrStb && tgt == vsc_pkg::TG_BAR)
            barR <= wrVal[7:0];
        else if (wrStb && tgt == vsc_pkg::TG_ADER)
            aderR[{~cfgOff[3:2], 3'b000} +: 8] <= wrVal[7:0];
    end

    // Flags: writing ones through the set place sets, through the
    // clear place clears.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            csrFlagsR <= 8'h00; // R7
        else if (wrStb && tgt == vsc_pkg::TG_BSET)
            csrFlagsR <= csrFlagsR | wrVal[7:0];
        else if (wrStb && tgt == vsc_pkg::TG_BCLR)
            csrFlagsR <= csrFlagsR & ~wrVal[7:0];
    end

    // Addressing control keeps the last value written.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            adrCtlR <= `VSC_ZERO32; // R7
        else if (wrStb && tgt == vsc_pkg::TG_ADRCTL)
            adrCtlR <= (adrCtlR & ~req.lanes) | wrVal; // R2 R15
    end

    // -----------------------------------------------------------------
    // Reset pulses
    // -----------------------------------------------------------------
    // A one written to a pulse bit other than 7 and 8, or the reset flag being set, fires
    // a fixed-length pulse; this logic needs no loaded gate array.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pulseR <= 10'h000;
            pulseCntR <= 8'h00;
        end
        else if (ce)
        begin
            if (wrStb && tgt == vsc_pkg::TG_PULSE &&
                (wrVal[9:0] & `VSC_PULSE_MASK) != 10'h000) // R14
            begin
                pulseR <= pulseR | (wrVal[9:0] & `VSC_PULSE_MASK);
                pulseCntR <= 8'(PULSE_CYC - 1);
            end
            else if (wrStb && tgt == vsc_pkg::TG_BSET &&
                wrVal[`VSC_FLAG_RESET]) // R14
            begin
                pulseR <= pulseR | 10'h001;
                pulseCntR <= 8'(PULSE_CYC - 1);
            end
            else if (pulseCntR != 8'h00)
                pulseCntR <= pulseCntR - 8'h01;
            else
                pulseR <= 10'h000;
        end
    end

    // -----------------------------------------------------------------
    // Mapped memory
    // -----------------------------------------------------------------
    // Word memory written with lane masking, cleared by reset.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                memR[i] <= `VSC_ZERO32; // R7
        end
        else if (wrStb && tgt == vsc_pkg::TG_MEM)
            memR[memIdx] <= (memR[memIdx] & ~req.lanes) | wrVal; // R8
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // Acknowledge is driven low only while a beat is answered.
    assign dtackOut = 1'b0;
    assign dtackOe = (stateR == vsc_pkg::ST_ACK); // R6 R22
    assign dataOe = (stateR == vsc_pkg::ST_ACK) && readR;
    assign dataOut = dataOutR;
    assign addrCtl = adrCtlR;
    assign ctlPulse = pulseR;
    assign csrFlags = csrFlagsR;

endmodule

// ==== vsc_slave_chk.sv ====
// Port assertions for the configuration-space slave.
`timescale 1ns/10ps
module vsc_slave_chk #(
    parameter int PULSE_CYC = 20
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [5:0] vmeAm,
    input wire logic asN,
    input wire logic ds0N,
    input wire logic ds1N,
    input wire logic writeN,
    input wire logic dataOe,
    input wire logic dtackOut,
    input wire logic dtackOe,
    input wire logic [31:0] addrCtl,
    input wire logic [9:0] ctlPulse
);
    // Counts high cycles of pulse line 0.
    int pulseCnt_r;
    always_ff @(posedge clock)
    begin
        pulseCnt_r <= (ctlPulse[0] && rst_n) ? pulseCnt_r + 1 : 0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_am_filter:
    assert property ($rose(dtackOe) |-> $past(vmeAm) inside
        {6'h2F, 6'h09, 6'h0B}) else $error("ack on bad modifier");
    a_ack_cause:
    assert property ($rose(dtackOe) |-> $past(!asN && !(ds0N && ds1N)))
        else $error("ack without strobes");
    a_ack_release:
    assert property (ce && dtackOe && ds0N && ds1N |=> !dtackOe)
        else $error("ack held after strobes");
    a_open_drain:
    assert property (dtackOe |-> !dtackOut) else $error("ack level");
    a_pulse_width:
    assert property ($fell(ctlPulse[0]) |-> pulseCnt_r == PULSE_CYC)
        else $error("pulse width");
    a_reset_clear:
    assert property ($rose(rst_n) |-> addrCtl == 32'h0000_0000 &&
        ctlPulse == 10'h000 && !dtackOe) else $error("reset values");
    a_ctl_write:
    assert property ($changed(addrCtl) |-> $past(!writeN && !asN))
        else $error("control changed without write");
    a_read_data:
    assert property ($rose(dataOe) |-> writeN && dtackOe)
        else $error("data driven outside read");
endmodule

// ==== vsc_vme_master.sv ====
// Crate master model that runs single beats at the slave pins.
`timescale 1ns/10ps
module vsc_vme_master (
    input wire logic clock,
    input wire logic dtackOe,
    input wire logic [31:0] dataOut,
    output logic [31:1] vmeAddr,
    output logic [5:0] vmeAm,
    output logic asN,
    output logic ds0N,
    output logic ds1N,
    output logic lwordN,
    output logic writeN,
    output logic [31:0] dataIn
);
    // Strobes idle high; released lines invert.
    initial
    begin
        {asN, ds0N, ds1N, lwordN, writeN} = 5'h1F;
        vmeAddr = '0;
        vmeAm = 6'h3F;
        dataIn = 32'h5A5A_5A5A;
    end
    // Width w: 0 byte, 1 D16, 2 D32; gives up after eight cycles.
    task automatic beat(input logic [31:0] a, input logic [5:0] am,
        input logic wr, input logic [31:0] wd, output logic [31:0] rd,
        output logic ack, input logic [1:0] w = 2'h2);
        ack = 1'b0;
        rd = '0;
        @(negedge clock);
        vmeAddr = a[31:1];
        vmeAm = am;
        writeN = !wr;
        dataIn = wr ? wd : ~dataIn;
        lwordN = (w != 2'h2);
        ds1N = (w == 2'h0);
        {asN, ds0N} = 2'h0;
        for (int n = 0; n < 8 && !ack; n++)
        begin
            @(posedge clock);
            ack = (dtackOe === 1'b1);
            rd = dataOut;
        end
        @(negedge clock);
        {asN, ds0N, ds1N} = 3'h7;
        dataIn = ~dataIn;
        vmeAddr = ~vmeAddr;
    endtask
endmodule

// ==== tb_vsc_slave.sv ====
// Self-checking bench for the configuration-space slave.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_vsc_slave;
    localparam logic [31:0] CFG = 32'h0028_0000; // Slot 5, A24.
    localparam logic [31:0] A32 = 32'h2800_0000; // Slot 5 window.
    localparam logic [31:0] STAT = 32'hA5C3_0F96;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic asN, ds0N, ds1N, lwordN, writeN, dataOe, dtackOut, dtackOe;
    logic [31:0] dataIn, dataOut, addrCtl;
    logic [31:1] vmeAddr;
    logic [9:0] ctlPulse;
    logic [7:0] csrFlags;
    logic [5:0] vmeAm;
    int n_errors = 0;
    int cmp_count = 0;
    vsc_slave #(.PULSE_CYC(2)) i_vsc_slave (.clock(clock), .rst_n(rst_n),
        .ce(1'b1), .vmeAddr(vmeAddr), .vmeAm(vmeAm), .asN(asN), .ds0N(ds0N),
        .ds1N(ds1N), .lwordN(lwordN), .writeN(writeN), .gaN(5'h1A),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .dtackOut(dtackOut), .dtackOe(dtackOe), .statusIn(STAT),
        .addrCtl(addrCtl), .ctlPulse(ctlPulse), .csrFlags(csrFlags));
    vsc_vme_master i_vsc_vme_master (.clock(clock), .dtackOe(dtackOe),
        .dataOut(dataOut), .vmeAddr(vmeAddr), .vmeAm(vmeAm), .asN(asN),
        .ds0N(ds0N), .ds1N(ds1N), .lwordN(lwordN), .writeN(writeN),
        .dataIn(dataIn));
    initial forever #5 clock = ~clock;
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Answered access; silence ends the run.
    task automatic acc(input logic [31:0] a, input logic [5:0] am,
        input logic wr, input logic [31:0] wd, output logic [31:0] rd,
        input logic [1:0] w = 2'h2);
        logic ack;
        i_vsc_vme_master.beat(a, am, wr, wd, rd, ack, w);
        `CHK("ack", 1'b1, ack)
        if (ack !== 1'b1)
            conclude();
    endtask
    task automatic t_rom();
        logic [31:0] rd;
        logic [7:0] off [8] = '{8'h03, 8'h0F, 8'h13, 8'h17, 8'h1B, 8'h1F,
            8'h23, 8'h53};
        logic [7:0] want [8] = '{8'h00, 8'h80, 8'h84, 8'h84, 8'h02, 8'h43,
            8'h53, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            acc(CFG | 32'(off[i]), 6'h2F, 1'b0, '0, rd, 2'(i % 3));
            `CHK("rom", want[i], rd[7:0])
        end
        acc(CFG | 32'h0000_0013, 6'h2F, 1'b1, 32'h0000_00FF, rd, 2'h0);
        acc(CFG | 32'h0000_0013, 6'h2F, 1'b0, '0, rd);
        `CHK("rom write", 8'h84, rd[7:0])
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        acc(A32 | 32'h0000_0014, 6'h09, 1'b0, '0, rd);
        `CHK("status", STAT, rd)
        acc(A32 | 32'h0000_0010, 6'h09, 1'b0, '0, rd);
        `CHK("ctl reset", 32'h0000_0000, rd)
        acc(CFG | 32'h0007_FBE8, 6'h2F, 1'b1, 32'h0000_0015, rd);
        `CHK("ctl port", 32'h0000_0015, addrCtl)
        acc(A32 | 32'h0000_0010, 6'h09, 1'b0, '0, rd);
        `CHK("ctl mirror", 32'h0000_0015, rd)
        acc(A32 | 32'h0000_0014, 6'h09, 1'b1, '0, rd);
        acc(CFG | 32'h0007_FBEC, 6'h2F, 1'b0, '0, rd);
        `CHK("status ro", STAT, rd)
    endtask
    task automatic t_pulse();
        logic [31:0] rd;
        acc(A32 | 32'h0000_0008, 6'h09, 1'b1, 32'h0000_03FF, rd);
        `CHK("pulse out", 10'h27F, ctlPulse)
        acc(A32 | 32'h0000_0008, 6'h09, 1'b0, '0, rd);
        `CHK("pulse read", 32'h0000_0000, rd)
        acc(CFG | 32'h0007_FBE4, 6'h2F, 1'b0, '0, rd);
        `CHK("pulse cfg", 32'h0000_0000, rd)
        `CHK("pulse end", 10'h000, ctlPulse)
        acc(CFG | 32'h0007_FFFB, 6'h2F, 1'b1, 32'h0000_0081, rd, 2'h0);
        `CHK("flags", 8'h81, csrFlags)
    endtask
    task automatic t_decode();
        logic [31:0] rd;
        logic ack;
        i_vsc_vme_master.beat(A32, 6'h39, 1'b0, '0, rd, ack);
        `CHK("bad am", 1'b0, ack)
        i_vsc_vme_master.beat(CFG ^ 32'h0008_0000, 6'h2F, 1'b0, '0, rd, ack);
        `CHK("bad slot", 1'b0, ack)
        i_vsc_vme_master.beat(A32 ^ 32'h0800_0000, 6'h09, 1'b0, '0, rd, ack);
        `CHK("bad base", 1'b0, ack)
        acc(A32 | 32'h0000_0030, 6'h09, 1'b0, '0, rd);
        `CHK("gap", 32'h0000_0000, rd)
        acc(A32 | 32'h0000_0010, 6'h09, 1'b1, 32'h0000_003F, rd);
        acc(32'hF800_0010, 6'h09, 1'b0, '0, rd);
        `CHK("override", 32'h0000_003F, rd)
        acc(32'hF800_0010, 6'h09, 1'b1, 32'h0000_0000, rd);
    endtask
    // Block beats reach memory only.
    task automatic t_blk();
        logic [31:0] rd;
        acc(A32 | 32'h0000_0200, 6'h0B, 1'b1, 32'hCAFE_0123, rd);
        acc(A32 | 32'h0000_0200, 6'h09, 1'b0, '0, rd);
        `CHK("mem", 32'hCAFE_0123, rd)
        acc(A32 | 32'h0000_0010, 6'h0B, 1'b1, 32'h0000_0007, rd);
        acc(A32 | 32'h0000_0010, 6'h09, 1'b0, '0, rd);
        `CHK("blk reg", 32'h0000_0000, rd)
    endtask
    initial
    begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        t_regs();
        t_rom();
        t_pulse();
        t_decode();
        t_blk();
        conclude();
    end
endmodule
bind vsc_slave vsc_slave_chk #(.PULSE_CYC(PULSE_CYC)) i_vsc_slave_chk (
    .clock(clock), .rst_n(rst_n), .ce(ce), .vmeAm(vmeAm), .asN(asN),
    .ds0N(ds0N), .ds1N(ds1N), .writeN(writeN), .dataOe(dataOe),
    .dtackOut(dtackOut), .dtackOe(dtackOe), .addrCtl(addrCtl),
    .ctlPulse(ctlPulse));
